// ===== logic/crs_pkg.sv
// constants, opcodes and states shared by the cpu register set
package crs_pkg;
    // micro-operations issued by the core sequencer
    typedef enum logic [4:0] {
        OP_NOP   = 5'h00,
        OP_LDA   = 5'h01,
        OP_LDX   = 5'h02,
        OP_ADD   = 5'h03,
        OP_ADC   = 5'h04,
        OP_SUB   = 5'h05,
        OP_AND   = 5'h06,
        OP_INC   = 5'h07,
        OP_DEC   = 5'h08,
        OP_LSL   = 5'h09,
        OP_ROL   = 5'h0a,
        OP_BTST  = 5'h0b,
        OP_FETCH = 5'h0c,
        OP_JUMP  = 5'h0d,
        OP_RSP   = 5'h0e,
        OP_CLI   = 5'h0f,
        OP_SEI   = 5'h10,
        OP_WAIT  = 5'h11,
        OP_CALL  = 5'h12,
        OP_RTI   = 5'h13
    } crs_op_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PUSH  = 3'b001,
        ST_VEC   = 3'b010,
        ST_PL_RD = 3'b011,
        ST_PL_WB = 3'b100
    } crs_state_e;

    // indexed address modes
    localparam logic [1:0] IX_NONE = 2'h0;
    localparam logic [1:0] IX_X0 = 2'h1;
    localparam logic [1:0] IX_X8 = 2'h2;
    localparam logic [1:0] IX_X16 = 2'h3;

    // stack addressing
    localparam logic [9:0] SP_FIXED_HI = 10'b0000000011;
    localparam logic [5:0] SP_RESET = 6'h3f;
    localparam logic [2:0] PUSH_IRQ_LAST = 3'h4;
    localparam logic [2:0] PUSH_CALL_LAST = 3'h1;
    localparam logic [2:0] PULL_RTI_LAST = 3'h4;
    localparam logic [2:0] PULL_VEC_LAST = 3'h1;
    localparam logic [15:0] RESET_VEC_HI = 16'h0ffe;

    // condition code bit positions
    localparam int CCR_C = 0;
    localparam int CCR_Z = 1;
    localparam int CCR_N = 2;
    localparam int CCR_I = 3;
    localparam int CCR_H = 4;
    localparam logic [2:0] CCR_ONES = 3'h7;

    // apb register offsets
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_IDX = 8'h04;
    localparam logic [7:0] OFS_SP = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0c;
    localparam logic [7:0] OFS_CCR = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
endpackage

// ===== logic/crs_regset.sv
// cpu programming-model register set with apb view
// Functional notes
// - only six stack pointer bits; wraps from 0x00C0 back to 0x00FF.
// - 8-bit accumulator holds operands and results; reset leaves it.
// - indexed address is X alone, X plus 8-bit or 16-bit offset.
// - 8-bit index register unchanged by reset, usable as storage.
// - stack pointer loads 0x00FF on reset and on reload instruction.
// - stack pointer decrements per push, increments per pull.
// - stack addresses carry fixed upper bits, range 0x00C0..0x00FF.
// - subroutine call stacks two bytes; interrupt entry stacks five.
// - 16-bit program counter increments per fetch, loads on jumps.
// - five condition bits, upper three always read as one.
// - reset sets mask; only unmask or wait instruction clear it; here an apb CCR write or the return pull also clears it.
// - half carry is carry from bit 3 to bit 4 on add.
// - mask set after registers stacked, before vector fetch.
// - masked interrupt request stays pending until mask clears.
// - return from handler pulls all registers, restoring the mask.
// - negative flag follows bit 7 of result, loads included.
// - zero flag set when result or loaded value is zero.
// - carry follows bit 7 carry, bit test, shifts and rotates.
// - add-one and subtract-one leave the carry flag alone.
// - reset loads program counter from 0x0FFE/0x0FFF, sets mask.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module crs_regset #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    // core micro-operation port
    input wire logic op_valid_in,
    input wire crs_pkg::crs_op_e op_code_in,
    input wire logic [7:0] op_data_in,
    input wire logic [15:0] op_addr_in,
    input wire logic [1:0] ix_mode_in,
    output logic op_ready_out,
    // interrupt request from interrupt logic
    input wire logic irq_req_in,
    output logic vec_req_out,
    // memory port for stacking and vectors
    input wire logic [7:0] mem_rdata_in,
    output logic mem_wr_out,
    output logic mem_rd_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    // register views
    output logic [7:0] acc_out,
    output logic [7:0] idx_out,
    output logic [15:0] sp_addr_out,
    output logic [15:0] pc_out,
    output logic [7:0] ccr_out,
    output logic [15:0] ea_out
);
    import crs_pkg::*;

    initial begin
        if (ADDR_W < 8 || ADDR_W > 16) begin
            $error("ADDR_W must lie in 8..16");
        end
    end

    localparam logic [15:0] PC_MASK = 16'((32'h1 << ADDR_W) - 1);

    logic [7:0] a_reg;
    logic [7:0] x_reg;
    logic [5:0] sp_reg;
    logic [15:0] pc_reg;
    logic [4:0] ccr_reg;
    logic [15:0] tgt_reg;
    logic [15:0] ea_reg;
    logic pend_reg;
    logic irq_mode_reg;
    logic vec_mode_reg;
    logic [2:0] step_reg;
    crs_state_e state_reg;
    crs_state_e state_next;
    logic op_rdy_reg;
    logic vec_reg;
    logic mem_wr_reg;
    logic mem_rd_reg;
    logic [15:0] mem_addr_reg;
    logic [7:0] mem_wdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    function automatic logic reg_hit(input logic [7:0] ofs);
        reg_hit = (ofs == OFS_ACC) || (ofs == OFS_IDX) ||
            (ofs == OFS_SP) || (ofs == OFS_PC) ||
            (ofs == OFS_CCR) || (ofs == OFS_STAT);
    endfunction

    function automatic logic [15:0] stack_addr(input logic [5:0] ptr);
        stack_addr = {SP_FIXED_HI, ptr};
    endfunction

    logic op_go;
    logic irq_go;
    logic apb_wr;
    assign op_go = ce_in && op_valid_in && op_rdy_reg;
    assign irq_go = ce_in && (state_reg == ST_IDLE) && !op_go &&
        pend_reg && !ccr_reg[CCR_I];
    assign apb_wr = psel_in && penable_in && pwrite_in && pready_reg &&
        (state_reg == ST_IDLE) && !op_go;

    // alu for single-cycle operations
    logic [8:0] sum9;
    logic [4:0] hsum;
    logic [7:0] res;
    logic c_new;
    logic upd_nz;
    logic upd_c;
    logic upd_h;
    logic wr_a;
    logic wr_x;
    always_comb begin
        sum9 = 9'h000;
        hsum = 5'h00;
        res = 8'h00;
        c_new = ccr_reg[CCR_C];
        upd_nz = 1'b0;
        upd_c = 1'b0;
        upd_h = 1'b0;
        wr_a = 1'b0;
        wr_x = 1'b0;
        case (op_code_in)
            OP_LDA: begin
                res = op_data_in;
                upd_nz = 1'b1;
                wr_a = 1'b1;
            end
            OP_LDX: begin
                res = op_data_in;
                upd_nz = 1'b1;
                wr_x = 1'b1;
            end
            OP_ADD, OP_ADC: begin
                hsum = {1'b0, a_reg[3:0]} + {1'b0, op_data_in[3:0]} +
                    {4'h0, ccr_reg[CCR_C] & (op_code_in == OP_ADC)};
                sum9 = {1'b0, a_reg} + {1'b0, op_data_in} +
                    {8'h00, ccr_reg[CCR_C] & (op_code_in == OP_ADC)};
                res = sum9[7:0];
                c_new = sum9[8];
                {upd_nz, upd_c, upd_h, wr_a} = 4'hf;
            end
            OP_SUB: begin
                sum9 = {1'b0, a_reg} - {1'b0, op_data_in};
                res = sum9[7:0];
                c_new = sum9[8];
                {upd_nz, upd_c, wr_a} = 3'h7;
            end
            OP_AND: begin
                res = a_reg & op_data_in;
                {upd_nz, wr_a} = 2'h3;
            end
            OP_INC, OP_DEC: begin
                // carry deliberately untouched
                res = (op_code_in == OP_INC) ? a_reg + 8'h01 :
                    a_reg - 8'h01;
                {upd_nz, wr_a} = 2'h3;
            end
            OP_LSL, OP_ROL: begin
                res = {a_reg[6:0],
                    ccr_reg[CCR_C] & (op_code_in == OP_ROL)};
                c_new = a_reg[7];
                {upd_nz, upd_c, wr_a} = 3'h7;
            end
            OP_BTST: begin
                c_new = op_data_in[op_addr_in[2:0]];
                upd_c = 1'b1;
            end
            default: begin
                res = 8'h00;
            end
        endcase
    end

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (op_go && op_code_in == OP_CALL) begin
                    state_next = ST_PUSH;
                end else if (op_go && op_code_in == OP_RTI) begin
                    state_next = ST_PL_RD;
                end else if (irq_go) begin
                    state_next = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (step_reg == (irq_mode_reg ? PUSH_IRQ_LAST :
                    PUSH_CALL_LAST)) begin
                    state_next = irq_mode_reg ? ST_VEC : ST_IDLE;
                end
            end
            ST_VEC: state_next = ST_IDLE;
            ST_PL_RD: state_next = ST_PL_WB;
            ST_PL_WB: begin
                state_next = (step_reg == (vec_mode_reg ? PULL_VEC_LAST :
                    PULL_RTI_LAST)) ? ST_IDLE : ST_PL_RD;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            // reset first fetches the reset vector
            state_reg <= ST_PL_RD;
            vec_mode_reg <= 1'b1;
            irq_mode_reg <= 1'b0;
            step_reg <= 3'h0;
            op_rdy_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else if (ce_in) begin
            state_reg <= state_next;
            op_rdy_reg <= (state_next == ST_IDLE) && !irq_go;
            // request held while masked; set wins over clear
            pend_reg <= irq_req_in || (pend_reg && !irq_go);
            if (state_reg == ST_IDLE) begin
                step_reg <= 3'h0;
                irq_mode_reg <= irq_go;
                vec_mode_reg <= 1'b0;
            end else if (state_reg == ST_PUSH || state_reg == ST_PL_WB) begin
                step_reg <= (state_next == state_reg ||
                    state_next == ST_PL_RD) ? step_reg + 3'h1 : 3'h0;
            end
        end
    end

    // memory port: pushes, pulls and vector reads
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            mem_wr_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
            mem_addr_reg <= 16'h0000;
            mem_wdata_reg <= 8'h00;
            vec_reg <= 1'b0;
        end else if (ce_in) begin
            mem_wr_reg <= (state_reg == ST_PUSH);
            mem_rd_reg <= (state_reg == ST_PL_RD);
            vec_reg <= (state_reg == ST_VEC);
            if (state_reg == ST_PUSH) begin
                mem_addr_reg <= stack_addr(sp_reg);
                case (step_reg)
                    3'h0: mem_wdata_reg <= pc_reg[7:0];
                    3'h1: mem_wdata_reg <= pc_reg[15:8];
                    3'h2: mem_wdata_reg <= x_reg;
                    3'h3: mem_wdata_reg <= a_reg;
                    default: mem_wdata_reg <= {CCR_ONES, ccr_reg};
                endcase
            end else if (state_reg == ST_PL_RD) begin
                mem_addr_reg <= vec_mode_reg ?
                    RESET_VEC_HI + {13'h0000, step_reg} :
                    stack_addr(sp_reg + 6'h01);
            end
        end
    end

    // programming-model registers
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            // accumulator, index and result flags keep their values
            sp_reg <= SP_RESET;
            ccr_reg[CCR_I] <= 1'b1;
            pc_reg <= 16'h0000;
            tgt_reg <= 16'h0000;
        end else if (ce_in) begin
            if (op_go) begin
                if (wr_a) begin
                    a_reg <= res;
                end
                if (wr_x) begin
                    x_reg <= res;
                end
                if (upd_nz) begin
                    ccr_reg[CCR_N] <= res[7];
                    ccr_reg[CCR_Z] <= (res == 8'h00);
                end
                if (upd_c) begin
                    ccr_reg[CCR_C] <= c_new;
                end
                if (upd_h) begin
                    ccr_reg[CCR_H] <= hsum[4];
                end
                case (op_code_in)
                    OP_FETCH: pc_reg <= pc_reg + 16'h0001;
                    OP_JUMP: pc_reg <= op_addr_in;
                    OP_RSP: sp_reg <= SP_RESET;
                    OP_CLI, OP_WAIT: ccr_reg[CCR_I] <= 1'b0;
                    OP_SEI: ccr_reg[CCR_I] <= 1'b1;
                    OP_CALL: tgt_reg <= op_addr_in;
                    default: tgt_reg <= tgt_reg;
                endcase
            end else if (apb_wr) begin
                case (paddr_in)
                    OFS_ACC: a_reg <= pwdata_in[7:0];
                    OFS_IDX: x_reg <= pwdata_in[7:0];
                    OFS_PC: pc_reg <= pwdata_in[15:0];
                    OFS_CCR: ccr_reg <= pwdata_in[4:0];
                    default: tgt_reg <= tgt_reg;
                endcase
            end
            if (state_reg == ST_PUSH) begin
                // six bits wrap below 0x00C0
                sp_reg <= sp_reg - 6'h01;
                if (irq_mode_reg && step_reg == PUSH_IRQ_LAST) begin
                    ccr_reg[CCR_I] <= 1'b1;
                end
                if (!irq_mode_reg && step_reg == PUSH_CALL_LAST) begin
                    pc_reg <= tgt_reg;
                end
            end
            if (state_reg == ST_PL_RD && !vec_mode_reg) begin
                sp_reg <= sp_reg + 6'h01;
            end
            if (state_reg == ST_PL_WB && vec_mode_reg) begin
                // reset vector is high byte first
                if (step_reg == 3'h0) begin
                    pc_reg[15:8] <= mem_rdata_in;
                end else begin
                    pc_reg[7:0] <= mem_rdata_in;
                end
            end else if (state_reg == ST_PL_WB) begin
                case (step_reg) // reverse of stacking
                    3'h0: ccr_reg <= mem_rdata_in[4:0];
                    3'h1: a_reg <= mem_rdata_in;
                    3'h2: x_reg <= mem_rdata_in;
                    3'h3: pc_reg[15:8] <= mem_rdata_in;
                    default: pc_reg[7:0] <= mem_rdata_in;
                endcase
            end
        end
    end

    // effective address for indexed modes
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ea_reg <= 16'h0000;
        end else if (ce_in) begin
            case (ix_mode_in)
                IX_X0: ea_reg <= {8'h00, x_reg};
                IX_X8: ea_reg <= {8'h00, x_reg} + {8'h00, op_addr_in[7:0]};
                IX_X16: ea_reg <= {8'h00, x_reg} + op_addr_in;
                default: ea_reg <= op_addr_in;
            endcase
        end
    end

    // apb slave: one wait state, answer registered
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce_in) begin
            pready_reg <= psel_in && penable_in && !pready_reg;
            pslverr_reg <= psel_in && penable_in && !pready_reg &&
                !reg_hit(paddr_in);
            if (psel_in && penable_in && !pready_reg && !pwrite_in) begin
                case (paddr_in)
                    OFS_ACC: prdata_reg <= {24'h000000, a_reg};
                    OFS_IDX: prdata_reg <= {24'h000000, x_reg};
                    OFS_SP: prdata_reg <= {16'h0000, stack_addr(sp_reg)};
                    OFS_PC: prdata_reg <= {16'h0000, pc_reg & PC_MASK};
                    OFS_CCR: prdata_reg <= {24'h000000, CCR_ONES, ccr_reg};
                    OFS_STAT: prdata_reg <= {27'h0000000, pend_reg,
                        op_rdy_reg, state_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign prdata_out = prdata_reg;
    assign op_ready_out = op_rdy_reg;
    assign vec_req_out = vec_reg;
    assign mem_wr_out = mem_wr_reg;
    assign mem_rd_out = mem_rd_reg;
    assign mem_addr_out = mem_addr_reg;
    assign mem_wdata_out = mem_wdata_reg;
    assign acc_out = a_reg;
    assign idx_out = x_reg;
    assign sp_addr_out = stack_addr(sp_reg);
    // upper address lines beyond the memory map are ignored
    assign pc_out = pc_reg & PC_MASK;
    assign ccr_out = {CCR_ONES, ccr_reg};
    assign ea_out = ea_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    property p_stack_range;
        mem_wr_reg |-> mem_addr_reg[15:6] == SP_FIXED_HI;
    endproperty
    a_stack_range: assert property (p_stack_range)
        else $error("stack write outside 0x00C0..0x00FF");

    property p_rsp;
        op_go && op_code_in == OP_RSP |=> sp_reg == SP_RESET;
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("stack pointer reload missed");

    property p_push_dec;
        state_reg == ST_PUSH && ce_in |=> sp_reg == $past(sp_reg) - 6'h01;
    endproperty
    a_push_dec: assert property (p_push_dec)
        else $error("stack pointer not decremented on push");

    property p_mask_after_push;
        state_reg == ST_PUSH && irq_mode_reg && ce_in &&
            step_reg == PUSH_IRQ_LAST |=> ccr_reg[CCR_I] && !vec_reg
            ##1 vec_reg;
    endproperty
    a_mask_after_push: assert property (p_mask_after_push)
        else $error("mask not set between stacking and vector");

    property p_incdec_c;
        op_go && (op_code_in == OP_INC || op_code_in == OP_DEC) |=>
            $stable(ccr_reg[CCR_C]);
    endproperty
    a_incdec_c: assert property (p_incdec_c)
        else $error("carry changed by add-one or subtract-one");

    property p_half;
        op_go && op_code_in == OP_ADD |=> ccr_reg[CCR_H] ==
            (({1'b0, $past(a_reg[3:0])} + {1'b0, $past(op_data_in[3:0])})
            > 5'h0f);
    endproperty
    a_half: assert property (p_half)
        else $error("half carry wrong after add");

    property p_load_nz;
        op_go && op_code_in == OP_LDA |=> ccr_reg[CCR_Z] ==
            ($past(op_data_in) == 8'h00) && ccr_reg[CCR_N] ==
            $past(op_data_in[7]);
    endproperty
    a_load_nz: assert property (p_load_nz)
        else $error("zero or negative wrong after load");

    property p_pending;
        irq_req_in && ce_in |=> pend_reg;
    endproperty
    a_pending: assert property (p_pending)
        else $error("interrupt request not held");

    property p_mask_only_cleared;
        ccr_reg[CCR_I] && !(op_go && (op_code_in == OP_CLI ||
            op_code_in == OP_WAIT)) && !apb_wr &&
            state_reg != ST_PL_WB |=> ccr_reg[CCR_I];
    endproperty
    a_mask_only_cleared: assert property (p_mask_only_cleared)
        else $error("mask cleared without unmask instruction");

    property p_irq_five;
        irq_go |=> ##1 mem_wr_reg [*5] ##1 !mem_wr_reg;
    endproperty
    a_irq_five: assert property (p_irq_five)
        else $error("interrupt entry did not stack five bytes");

    c_irq_entry: cover property (irq_go);
    c_call: cover property (op_go && op_code_in == OP_CALL);
    c_rti: cover property (op_go && op_code_in == OP_RTI);
    c_sp_wrap: cover property (state_reg == ST_PUSH && sp_reg == 6'h00);
endmodule

// ===== testbench/crs_mem_model.sv
// memory model for the stack and vector port
`timescale 1ns/1ps
module crs_mem_model (
    // memory port
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem_q [0:4095];
    logic [7:0] last_q = 8'h00;
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem_q[addr_in[11:0]] <= wdata_in;
        end
        if (rd_in) begin
            last_q <= rdata_out;
        end
    end
    // idle bus shows the complement of the last byte read, never a stale byte
    assign rdata_out = rd_in ? mem_q[addr_in[11:0]] : ~last_q;
endmodule

// ===== testbench/crs_regset_tb_top.sv
// self-checking bench for the cpu register set
`timescale 1ns/1ps
module crs_regset_tb_top;
    import crs_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, opv = 0, irq = 0;
    logic [7:0] paddr = 8'h00, opd = 8'h00, x, r;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] opa = 16'h0;
    logic [1:0] ixm = 2'h0;
    crs_op_e opc = OP_NOP;
    logic pready, pslverr, opr, vreq, mrd, mwr;
    logic [31:0] prdata;
    logic [15:0] maddr, spa, pc, ea;
    logic [7:0] mwd, mrdata, acc, idx, condition_code_register;
    logic [32:0] expq[$];
    int n_errors = 0, n_compared = 0, n_vec = 0, k;
    crs_regset crs_regset_inst (.clk_in(clk), .nrst_in(nrst), .ce_in(1'b1),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr), .op_valid_in(opv),
        .op_code_in(opc), .op_data_in(opd), .op_addr_in(opa),
        .ix_mode_in(ixm), .op_ready_out(opr), .irq_req_in(irq),
        .vec_req_out(vreq), .mem_rdata_in(mrdata), .mem_wr_out(mwr),
        .mem_rd_out(mrd), .mem_addr_out(maddr), .mem_wdata_out(mwd),
        .acc_out(acc), .idx_out(idx), .sp_addr_out(spa), .pc_out(pc),
        .ccr_out(condition_code_register), .ea_out(ea));
    crs_mem_model crs_mem_model_inst (.clk_in(clk), .rd_in(mrd),
        .wr_in(mwr), .addr_in(maddr), .wdata_in(mwd), .rdata_out(mrdata));
    function automatic logic [7:0] m(input int a);
        return crs_mem_model_inst.mem_q[a];
    endfunction
    task automatic chk(input logic [32:0] s, input logic [32:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // pready is sampled at the rising edge, then the request drops
        k = 0;
        do @(posedge clk); while (pready !== 1'b1 && k++ < 20);
        if (pready !== 1'b1) begin
            n_errors++;
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_rdy;
        k = 0;
        do @(negedge clk); while (opr !== 1'b1 && k++ < 40);
        if (opr !== 1'b1) begin
            n_errors++;
        end
    endtask
    task automatic op(input crs_op_e c, input logic [7:0] d, input logic [15:0] a);
        @(posedge clk);
        opv <= 1'b1;
        opc <= c;
        opd <= d;
        opa <= a;
        wait_rdy();
        @(posedge clk);
        opv <= 1'b0;
        wait_rdy();
    endtask
    // read results are matched against the oldest note in order
    always @(negedge clk) begin
        if (pready === 1'b1 && pwr === 1'b0) begin
            chk({pslverr, prdata}, expq.pop_front());
        end
        if (vreq === 1'b1) begin
            n_vec++;
        end
    end
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        #(20000 * 50);
        n_errors++;
        close_out();
    end
    initial begin
        r = 8'($urandom(32'h33b6));
        crs_mem_model_inst.mem_q[12'hffe] = 8'h03;
        crs_mem_model_inst.mem_q[12'hfff] = 8'h45;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        wait_rdy();
        chk({spa, condition_code_register[7:5], condition_code_register[CCR_I]}, {16'h00ff, CCR_ONES, 1'b1});
        chk(pc, 16'h0345);
        @(posedge clk);
        irq <= 1'b1;
        repeat (20) @(posedge clk);
        irq <= 1'b0;
        chk(n_vec, 0);
        r = 8'($urandom);
        op(OP_LDA, r, 16'h0);
        rd(OFS_ACC, {25'h0, r});
        chk(condition_code_register[2:1], {r[7], r == 8'h00});
        op(OP_LDA, 8'h00, 16'h0);
        chk(condition_code_register[CCR_Z], 1'b1);
        op(OP_LDA, 8'h0f, 16'h0);
        op(OP_ADD, 8'h01, 16'h0);
        chk({acc, condition_code_register[CCR_H], condition_code_register[CCR_C]}, {8'h10, 2'b10});
        op(OP_ADD, 8'hf0, 16'h0);
        chk({acc, condition_code_register[CCR_H], condition_code_register[CCR_Z], condition_code_register[CCR_C]}, 11'h003);
        op(OP_DEC, 8'h00, 16'h0);
        chk({acc, condition_code_register[CCR_C]}, {8'hff, 1'b1});
        op(OP_LSL, 8'h00, 16'h0);
        chk({acc, condition_code_register[CCR_C]}, {8'hfe, 1'b1});
        x = 8'($urandom);
        op(OP_LDX, x, 16'h0);
        rd(OFS_IDX, {25'h0, x});
        for (int i = 1; i < 4; i++) begin
            @(posedge clk);
            ixm <= 2'(i);
            opa <= 16'h12f0;
            @(posedge clk);
            @(negedge clk);
            chk(ea, (i == 1) ? {8'h00, x} : (i == 2) ? {8'h00, x} + 16'h00f0 : 16'h12f0 + {8'h00, x});
        end
        op(OP_FETCH, 8'h00, 16'h0);
        chk(pc, 16'h0346);
        op(OP_CALL, 8'h00, 16'h0200);
        // second stacked byte lands one edge after op_ready returns
        @(negedge clk);
        chk({spa, pc, m(255), m(254)}, 48'h00fd_0200_4603);
        op(OP_RSP, 8'h00, 16'h0);
        chk(spa, 16'h00ff);
        repeat (31) op(OP_CALL, 8'h00, 16'h0200);
        chk(spa, 16'h00c1);
        op(OP_CALL, 8'h00, 16'h0200);
        rd(OFS_SP, 33'h00ff);
        op(OP_CLI, 8'h00, 16'h0);
        k = 0;
        while (n_vec == 0 && k++ < 40) @(negedge clk);
        chk({spa, condition_code_register[CCR_I]}, {16'h00fa, 1'b1});
        chk({m(253), m(252), m(251) & 8'h08}, {x, 16'hfe00});
        op(OP_JUMP, 8'h00, 16'h0400);
        op(OP_RTI, 8'h00, 16'h0);
        chk({spa, condition_code_register[CCR_I], pc}, {16'h00ff, 1'b0, 16'h0200});
        apb(1'b1, OFS_ACC, 32'h5a);
        rd(OFS_ACC, 33'h5a);
        rd(8'h18, {1'b1, 32'h0});
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule
